// [hw/lcell_flops.v]
`timescale 1ns/1ps
`default_nettype none

module lcell_flops (
  input  wire       clk,
  input  wire       nrst,
  input  wire       clear_en,
  input  wire       clear_in,
  input  wire       config_active,
  input  wire       cell_edge,
  input  wire       hold_en,
  input  wire       hold_enable_in,
  input  wire [1:0] data_in,
  output reg  [1:0] state
);

  // ********************************************
  // clear and enable qualification
  // ********************************************
  // clear acts without the clock, but only once enabled
  wire clear_n;
  wire take;

  assign clear_n = nrst & ~(clear_en & clear_in);
  // a disabled hold input counts as always high
  assign take = cell_edge & (~hold_en | hold_enable_in);

  // ********************************************
  // the two storage flops
  // ********************************************
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ff
      always @(posedge clk or negedge clear_n) begin
        if (!clear_n) begin
          state[i] <= 1'b0;
        end else if (config_active) begin
          state[i] <= 1'b0;
        end else if (take) begin
          state[i] <= data_in[i];
        end
      end
    end
  endgenerate

endmodule // lcell_flops

`default_nettype wire

// [hw/lcell_lut.v]
`timescale 1ns/1ps
`default_nettype none
`include "lcell_defs.vh"

module lcell_lut (
  input  wire [31:0] table_bits,
  input  wire [1:0]  mode,
  input  wire        var_a,
  input  wire        var_d,
  input  wire        var_e,
  input  wire        f_v2,
  input  wire        f_v3,
  input  wire        f_v4,
  input  wire        g_v2,
  input  wire        g_v3,
  input  wire        g_v4,
  output reg         func_f,
  output reg         func_g
);

  // ********************************************
  // table address forming
  // ********************************************
  // dual mode splits the table into two halves of sixteen
  wire [4:0] idx_f;
  wire [4:0] idx_g;
  wire [4:0] idx_one;

  assign idx_f   = {`LCELL_HALF_F, f_v4, f_v3, f_v2, var_a};
  assign idx_g   = {`LCELL_HALF_G, g_v4, g_v3, g_v2, var_a};
  // e picks the half: one five-input function, or two muxed
  assign idx_one = {var_e, var_d, f_v3, f_v2, var_a};

  // ********************************************
  // function outputs
  // ********************************************
  // reserved mode code behaves as dual mode
  always @* begin
    if (mode == `LCELL_MODE_ONE || mode == `LCELL_MODE_MUX) begin
      func_f = table_bits[idx_one];
      func_g = table_bits[idx_one];
    end else begin
      func_f = table_bits[idx_f];
      func_g = table_bits[idx_g];
    end
  end

endmodule // lcell_lut

`default_nettype wire

// [hw/lcell_top.v]
// What this block does
// - logic section, two flops, five inputs, data, clock, clear, enable, two outputs
// - each flop loads the first function, second function or direct data
// - enabled clear high clears both flops at once, over all clocked activity
// - both flops are zero under chip reset and during configuration
// - hold enable low keeps both flop states on every active edge
// - hold enable and clear each switch on by configuration, else inert
// - a configuration bit inverts the cell clock, choosing the active edge
// - functions come from a 32 entry table on inputs and flop states
// - dual mode: two four-input functions sharing input one
// - single mode: one function of inputs one, four, five and two picks
// - muxed mode: input five chooses between two four-input functions
// - single and muxed modes give both function outputs the same value
// - dual mode results may feed either flop and either output
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.

`timescale 1ns/1ps
`default_nettype none
`include "lcell_defs.vh"

module lcell_top (
  input  wire        clk,
  input  wire        nrst,
  // wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // cell side
  input  wire [4:0]  logic_in,
  input  wire        direct_data_in,
  input  wire        cell_clk,
  input  wire        clear_in,
  input  wire        hold_enable_in,
  output wire        cell_out_x,
  output wire        cell_out_y
);

  // ********************************************
  // helper functions
  // ********************************************

  // byte-lane merge for a write
  function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  sel;
    integer      k;
    begin
      merge_bytes = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          merge_bytes[k*8 +: 8] = new_val[k*8 +: 8];
        end
      end
    end
  endfunction

  // pick one of b, c and the two flop states
  function pick_var;
    input [1:0] sel;
    input       vb;
    input       vc;
    input       qx;
    input       qy;
    begin
      case (sel)
        `LCELL_VAR_B:  pick_var = vb;
        `LCELL_VAR_C:  pick_var = vc;
        `LCELL_VAR_QX: pick_var = qx;
        default:       pick_var = qy;
      endcase
    end
  endfunction

  // pick a flop data source
  function pick_src;
    input [1:0] sel;
    input       ff;
    input       gg;
    input       di;
    begin
      case (sel)
        `LCELL_SRC_F: pick_src = ff;
        `LCELL_SRC_G: pick_src = gg;
        default:      pick_src = di;
      endcase
    end
  endfunction

  // pick what an output presents
  function pick_out;
    input [1:0] sel;
    input       ff;
    input       gg;
    input       q1;
    input       q2;
    begin
      case (sel)
        `LCELL_OUT_F:  pick_out = ff;
        `LCELL_OUT_G:  pick_out = gg;
        `LCELL_OUT_Q1: pick_out = q1;
        default:       pick_out = q2;
      endcase
    end
  endfunction

  // one offset compare, shared by the read mux and the write path
  function adr_hit;
    input [7:0] adr;
    input [7:0] off;
    begin
      adr_hit = (adr == off);
    end
  endfunction

  // ********************************************
  // declarations
  // ********************************************
  reg  [31:0]                lut_table;
  reg  [`LCELL_MODE_W-1:0]   mode_cfg;
  reg  [`LCELL_CTRL_W-1:0]   ctrl_cfg;
  reg                        prev_clk;
  reg  [31:0]                next_rdata;

  wire                       bus_req;
  wire                       bus_wr;
  wire [31:0]                mode_wide;
  wire [31:0]                ctrl_wide;
  wire [31:0]                stat_wide;
  wire [`LCELL_STAT_W-1:0]   stat_bits;
  wire                       hit_lut;
  wire                       hit_mode;
  wire                       hit_ctrl;
  wire                       hit_stat;
  wire [31:0]                mode_merged;
  wire [31:0]                ctrl_merged;

  wire [1:0]                 flop_state;
  wire                       first_flop_state;
  wire                       second_flop_state;
  wire                       clk_eff;
  wire                       cell_edge;

  wire                       var_a;
  wire                       var_b;
  wire                       var_c;
  wire                       var_d;
  wire                       var_e;
  wire                       f_v2;
  wire                       f_v3;
  wire                       f_v4;
  wire                       g_v2;
  wire                       g_v3;
  wire                       g_v4;
  wire                       func_f;
  wire                       func_g;
  wire [1:0]                 flop_data;

  // ********************************************
  // bus slave
  // ********************************************

  // a request is served once; ack then drops for a cycle
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i;

  // offset decode, done once so reads and writes cannot disagree
  assign hit_lut  = adr_hit(wb_adr_i, `LCELL_ADR_LUT);
  assign hit_mode = adr_hit(wb_adr_i, `LCELL_ADR_MODE);
  assign hit_ctrl = adr_hit(wb_adr_i, `LCELL_ADR_CTRL);
  assign hit_stat = adr_hit(wb_adr_i, `LCELL_ADR_STAT);

  // zero-extended views of the stored fields
  assign mode_wide = {{(32-`LCELL_MODE_W){1'b0}}, mode_cfg};
  assign ctrl_wide = {{(32-`LCELL_CTRL_W){1'b0}}, ctrl_cfg};
  assign stat_wide = {{(32-`LCELL_STAT_W){1'b0}}, stat_bits};

  // status shows live cell state, read only
  assign stat_bits = {ctrl_cfg[`LCELL_C_CONFIG],
                      cell_out_y, cell_out_x,
                      func_g, func_f,
                      second_flop_state, first_flop_state};

  // read mux; unmapped offsets read zero
  always @* begin
    if (hit_lut) begin
      next_rdata = lut_table;
    end else if (hit_mode) begin
      next_rdata = mode_wide;
    end else if (hit_ctrl) begin
      next_rdata = ctrl_wide;
    end else if (hit_stat) begin
      next_rdata = stat_wide;
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  // ack and read data, one cycle after the request
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // ********************************************
  // configuration registers
  // ********************************************

  // merge on the wide views; upper bits beyond a field are dropped
  assign mode_merged = merge_bytes(mode_wide, wb_dat_i, wb_sel_i);
  assign ctrl_merged = merge_bytes(ctrl_wide, wb_dat_i, wb_sel_i);

  // writes land at the same edge the ack rises
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lut_table <= `LCELL_LUT_RST;
      mode_cfg  <= `LCELL_MODE_RST;
      ctrl_cfg  <= `LCELL_CTRL_RST;
    end else if (bus_wr) begin
      if (hit_lut) begin
        lut_table <= merge_bytes(lut_table, wb_dat_i, wb_sel_i);
      end else if (hit_mode) begin
        mode_cfg <= mode_merged[`LCELL_MODE_W-1:0];
      end else if (hit_ctrl) begin
        ctrl_cfg <= ctrl_merged[`LCELL_CTRL_W-1:0];
      end
    end
  end

  // ********************************************
  // cell clock polarity and edge
  // ********************************************

  // the cell clock is sampled; inverting it moves the edge
  assign clk_eff = cell_clk ^ ctrl_cfg[`LCELL_C_CLKINV];

  // previous level, so a rising effective level is one edge
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_clk <= 1'b0;
    end else begin
      prev_clk <= clk_eff;
    end
  end

  // a polarity change while high can fake one edge
  assign cell_edge = clk_eff & ~prev_clk;

  // ********************************************
  // variable selection
  // ********************************************

  assign var_a = logic_in[0];
  assign var_b = logic_in[1];
  assign var_c = logic_in[2];
  assign var_d = logic_in[3];
  assign var_e = logic_in[4];

  assign first_flop_state  = flop_state[0];
  assign second_flop_state = flop_state[1];

  // two free picks per function among b, c and the flops
  assign f_v2 = pick_var(mode_cfg[`LCELL_M_FV2], var_b, var_c,
                         first_flop_state, second_flop_state);
  assign f_v3 = pick_var(mode_cfg[`LCELL_M_FV3], var_b, var_c,
                         first_flop_state, second_flop_state);
  assign g_v2 = pick_var(mode_cfg[`LCELL_M_GV2], var_b, var_c,
                         first_flop_state, second_flop_state);
  assign g_v3 = pick_var(mode_cfg[`LCELL_M_GV3], var_b, var_c,
                         first_flop_state, second_flop_state);

  // fourth dual-mode variable is input four or five
  assign f_v4 = mode_cfg[`LCELL_M_FV4] ? var_e : var_d;
  assign g_v4 = mode_cfg[`LCELL_M_GV4] ? var_e : var_d;

  // ********************************************
  // lookup table
  // ********************************************
  lcell_lut u_lut (
    .table_bits (lut_table),
    .mode       (mode_cfg[`LCELL_M_MODE]),
    .var_a      (var_a),
    .var_d      (var_d),
    .var_e      (var_e),
    .f_v2       (f_v2),
    .f_v3       (f_v3),
    .f_v4       (f_v4),
    .g_v2       (g_v2),
    .g_v3       (g_v3),
    .g_v4       (g_v4),
    .func_f     (func_f),
    .func_g     (func_g)
  );

  // ********************************************
  // flop data sources
  // ********************************************

  // either function or the direct input, per flop
  assign flop_data[0] = pick_src(ctrl_cfg[`LCELL_C_SRC1], func_f,
                                 func_g, direct_data_in);
  assign flop_data[1] = pick_src(ctrl_cfg[`LCELL_C_SRC2], func_f,
                                 func_g, direct_data_in);

  // ********************************************
  // the two flops
  // ********************************************
  lcell_flops u_flops (
    .clk            (clk),
    .nrst           (nrst),
    .clear_en       (ctrl_cfg[`LCELL_C_CLREN]),
    .clear_in       (clear_in),
    .config_active  (ctrl_cfg[`LCELL_C_CONFIG]),
    .cell_edge      (cell_edge),
    .hold_en        (ctrl_cfg[`LCELL_C_HOLDEN]),
    .hold_enable_in (hold_enable_in),
    .data_in        (flop_data),
    .state          (flop_state)
  );

  // ********************************************
  // cell outputs
  // ********************************************

  // combinational by nature: a function output has no flop
  assign cell_out_x = pick_out(ctrl_cfg[`LCELL_C_XSEL], func_f,
                               func_g, first_flop_state,
                               second_flop_state);
  assign cell_out_y = pick_out(ctrl_cfg[`LCELL_C_YSEL], func_f,
                               func_g, first_flop_state,
                               second_flop_state);

endmodule // lcell_top

`default_nettype wire

// [inc/lcell_defs.vh]
`ifndef LCELL_DEFS_VH
`define LCELL_DEFS_VH

// ********************************************
// register byte offsets
// ********************************************
`define LCELL_ADR_LUT    8'h00
`define LCELL_ADR_MODE   8'h04
`define LCELL_ADR_CTRL   8'h08
`define LCELL_ADR_STAT   8'h0c

// ********************************************
// reset values
// ********************************************
`define LCELL_LUT_RST    32'h0000_0000
`define LCELL_MODE_RST   13'h0000
// configuration phase is active out of reset
`define LCELL_CTRL_RST   12'h800

// ********************************************
// mode register fields
// ********************************************
`define LCELL_MODE_W     13
`define LCELL_M_MODE     1:0
`define LCELL_M_FV2      3:2
`define LCELL_M_FV3      5:4
`define LCELL_M_FV4      6
`define LCELL_M_GV2      9:8
`define LCELL_M_GV3      11:10
`define LCELL_M_GV4      12

// ********************************************
// control register fields
// ********************************************
`define LCELL_CTRL_W     12
`define LCELL_C_SRC1     1:0
`define LCELL_C_SRC2     3:2
`define LCELL_C_XSEL     5:4
`define LCELL_C_YSEL     7:6
`define LCELL_C_HOLDEN   8
`define LCELL_C_CLREN    9
`define LCELL_C_CLKINV   10
`define LCELL_C_CONFIG   11

// ********************************************
// status register width
// ********************************************
`define LCELL_STAT_W     7

// ********************************************
// encodings
// ********************************************
`define LCELL_MODE_DUAL  2'h0
`define LCELL_MODE_ONE   2'h1
`define LCELL_MODE_MUX   2'h2
`define LCELL_VAR_B      2'h0
`define LCELL_VAR_C      2'h1
`define LCELL_VAR_QX     2'h2
`define LCELL_VAR_QY     2'h3
`define LCELL_SRC_F      2'h0
`define LCELL_SRC_G      2'h1
`define LCELL_SRC_DI     2'h2
`define LCELL_OUT_F      2'h0
`define LCELL_OUT_G      2'h1
`define LCELL_OUT_Q1     2'h2
`define LCELL_OUT_Q2     2'h3
`define LCELL_HALF_F     1'h0
`define LCELL_HALF_G     1'h1

`endif

// [verif/lcell_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************
// port checker for the cell
// ****************************
module lcell_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        direct_data_in,
  input wire logic        cell_clk,
  input wire logic        clear_in,
  input wire logic        hold_enable_in,
  input wire logic        cell_out_x,
  input wire logic        cell_out_y
);
  logic [11:0] sh;  // shadow of the control register
  logic        eq;  // effective cell clock at the last edge
  wire wr  = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i;
  wire eff = cell_clk ^ sh[10];
  wire ld  = eff & ~eq;
  wire clr = sh[9] & clear_in;
  wire qx  = sh[5:4] == 2'h2;
  // shadow moves at the taking edge, as the real register does
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh <= 12'h800;
      eq <= 1'b0;
    end else begin
      eq <= eff;
      if (wr && wb_adr_i == 8'h08 && wb_sel_i[0])
        sh[7:0] <= wb_dat_i[7:0];
      if (wr && wb_adr_i == 8'h08 && wb_sel_i[1])
        sh[11:8] <= wb_dat_i[11:8];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // a request taken by the slave
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // flop one on x, with no write, clear or configuration in play
  sequence s_calm;
    !wr && !sh[11] && !clr && qx;
  endsequence
  a_ack_next: assert property (s_take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_unmap_zero: assert property (s_take ##0 (!wb_we_i && wb_adr_i > 8'h0c)
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_cfg_zero: assert property (sh[11] && $past(sh[11])
    |-> !(qx && cell_out_x) && !(sh[7:6] == 2'h3 && cell_out_y))
    else $error("flop not zero in configuration");
  a_clear_now: assert property (clr
    |-> !(qx && cell_out_x) && !(sh[7:6] == 2'h3 && cell_out_y))
    else $error("flop not cleared at once");
  a_hold_keeps: assert property (s_calm ##0 (sh[8] && !hold_enable_in)
    |=> clr || $stable(cell_out_x)) else $error("held flop changed");
  a_no_edge: assert property (s_calm ##0 !ld
    |=> clr || $stable(cell_out_x)) else $error("flop moved off edge");
  a_di_load: assert property (s_calm ##0 (ld && sh[1]
    && (!sh[8] || hold_enable_in))
    |=> clr || cell_out_x == $past(direct_data_in))
    else $error("direct data not loaded");
endmodule // lcell_chk

bind lcell_top lcell_chk u_chk (
  .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .direct_data_in(direct_data_in), .cell_clk(cell_clk),
  .clear_in(clear_in), .hold_enable_in(hold_enable_in),
  .cell_out_x(cell_out_x), .cell_out_y(cell_out_y)
);
`default_nettype wire

// [verif/lcell_nbr.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************
// neighbouring logic model
// ****************************
module lcell_nbr (
  input  wire logic  clk,
  output logic [4:0] logic_in,
  output logic       direct_data_in,
  output logic       cell_clk,
  output logic       clear_in,
  output logic       hold_enable_in
);
  // all low at start; the cell clock stands still between uses
  initial begin
    logic_in = 5'h00;
    direct_data_in = 1'b0;
    cell_clk = 1'b0;
    clear_in = 1'b0;
    hold_enable_in = 1'b0;
  end
  // new levels just after an edge, then one cycle to settle
  task automatic drive(input logic [4:0] a, input logic d, h, c);
    @(posedge clk);
    logic_in <= a;
    direct_data_in <= d;
    hold_enable_in <= h;
    clear_in <= c;
    @(posedge clk);
    #1;
  endtask
  // a clock level held two cycles, so each phase is sampled
  task automatic level(input logic v);
    @(posedge clk);
    cell_clk <= v;
    repeat (2) @(posedge clk);
    #1;
  endtask
endmodule // lcell_nbr
`default_nettype wire

// [verif/lcell_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************
// bench
// ****************************
module lcell_top_tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic [31:0] lut;
  logic [12:0] md;
  logic [1:0]  e;
  logic        q1 = 1'b0;
  logic        q2 = 1'b0;
  logic        d0;
  wire  [31:0] dat_o;
  wire         ack;
  wire         x;
  wire         y;
  wire  [4:0]  li;
  wire         di;
  wire         kc;
  wire         cl;
  wire         he;
  int          n_mismatch = 0;
  int          checked = 0;
  // 250 MHz system clock
  always #2 clk = ~clk;
  lcell_top dut (
    .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .logic_in(li),
    .direct_data_in(di), .cell_clk(kc), .clear_in(cl),
    .hold_enable_in(he), .cell_out_x(x), .cell_out_y(y)
  );
  lcell_nbr nbr (
    .clk(clk), .logic_in(li), .direct_data_in(di), .cell_clk(kc),
    .clear_in(cl), .hold_enable_in(he)
  );
  // expected {g, f}; single and muxed share one table view
  function automatic logic [1:0] fg(input logic [31:0] t,
    input logic [12:0] m, input logic [4:0] i, input logic a, b);
    logic [3:0] v;
    v = {b, a, i[2], i[1]};
    if (m[1:0] == 2'h1 || m[1:0] == 2'h2)
      return {2{t[{i[4], i[3], v[m[5:4]], v[m[3:2]], i[0]}]}};
    return {t[{1'b1, m[12] ? i[4] : i[3], v[m[11:10]], v[m[9:8]], i[0]}],
            t[{1'b0, m[6] ? i[4] : i[3], v[m[5:4]], v[m[3:2]], i[0]}]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; waits for ack, only the watchdog ends a hang
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    chk(32'(n), 32'h2); // ack one cycle after the taking edge
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // set control, run one cell clock, follow both flops
  task automatic step(input logic [11:0] c, input logic h);
    logic [4:0] a;
    logic       d;
    logic [1:0] f;
    a = 5'($urandom);
    d = 1'($urandom);
    wb(1'b1, 8'h08, 32'(c), 4'hf, rd);
    nbr.drive(a, d, h, 1'b0);
    nbr.level(1'b1);
    nbr.level(1'b0);
    f = fg(lut, md, a, q1, q2);
    if (!c[8] || h) begin
      q1 = c[1] ? d : f[c[0]];
      q2 = c[3] ? d : f[c[2]];
    end
    chk(x, q1);
    chk(y, q2);
  endtask
  task test_done;
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ****************************
  // tests
  // ****************************
  initial begin
    void'($urandom(2));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wb(1'b0, 8'h08, 32'h0, 4'h0, rd);
    chk(rd, 32'h800);
    wb(1'b0, 8'h0c, 32'h0, 4'h0, rd);
    chk(rd, 32'h40);
    wb(1'b0, 8'h10, 32'h0, 4'h0, rd);
    chk(rd, 32'h0);
    wb(1'b1, 8'h00, 32'h12345678, 4'hf, rd);
    wb(1'b1, 8'h00, 32'hffffffff, 4'h5, rd);
    wb(1'b1, 8'h40, 32'h0, 4'hf, rd);
    wb(1'b0, 8'h00, 32'h0, 4'h0, rd);
    chk(rd, 32'h12ff56ff);
    $display("test registers done");
    // every mode, flops held at zero by configuration
    for (int k = 0; k < 24; k++) begin
      lut = $urandom;
      md = 13'($urandom);
      md[1:0] = 2'(k);
      wb(1'b1, 8'h00, lut, 4'hf, rd);
      wb(1'b1, 8'h04, 32'(md), 4'hf, rd);
      wb(1'b1, 8'h08, 32'h840, 4'hf, rd);
      nbr.drive(5'($urandom), 1'($urandom), 1'($urandom), 1'b0);
      e = fg(lut, md, li, 1'b0, 1'b0);
      chk(x, e[0]);
      chk(y, e[1]);
      wb(1'b0, 8'h0c, 32'h0, 4'h0, rd);
      chk(rd[3:2], e);
    end
    $display("test functions done");
    lut = $urandom;
    wb(1'b1, 8'h00, lut, 4'hf, rd);
    md = 13'h0;
    wb(1'b1, 8'h04, 32'(md), 4'hf, rd);
    for (int s = 0; s < 3; s++)
      step(12'h0e0 | 12'(((s + 1) % 3) << 2) | 12'(s), 1'b1);
    step(12'h1e2, 1'b0);
    step(12'h1e2, 1'b1);
    step(12'h0e2, 1'b0);
    // any mode, so flop states also feed the table
    md = 13'($urandom);
    wb(1'b1, 8'h04, 32'(md), 4'hf, rd);
    repeat (12) step((12'($urandom) & 12'h30f) | 12'h0e0, 1'($urandom));
    $display("test flops done");
    // active edge moved to the falling cell clock
    d0 = !q1;
    wb(1'b1, 8'h08, 32'h0ea, 4'hf, rd);
    nbr.drive(5'($urandom), d0, 1'($urandom), 1'b0);
    nbr.level(1'b1);
    wb(1'b1, 8'h08, 32'h4ea, 4'hf, rd);
    nbr.drive(5'($urandom), !d0, 1'($urandom), 1'b0);
    chk(x, d0);
    nbr.level(1'b0);
    chk(x, !d0);
    nbr.drive(5'($urandom), d0, 1'($urandom), 1'b0);
    nbr.level(1'b1);
    chk(y, !d0);
    wb(1'b1, 8'h08, 32'h0ea, 4'hf, rd);
    nbr.level(1'b0);
    chk(x, d0);
    $display("test clock sense done");
    // clear ignored while disabled, then dominant over the clock
    nbr.drive(5'($urandom), 1'b1, 1'($urandom), 1'b0);
    nbr.level(1'b1);
    nbr.level(1'b0);
    nbr.drive(5'($urandom), 1'b1, 1'($urandom), 1'b1);
    chk(x, 1'b1);
    wb(1'b1, 8'h08, 32'h2ea, 4'hf, rd);
    chk(y, 1'b0);
    nbr.level(1'b1);
    nbr.level(1'b0);
    chk(x, 1'b0);
    nbr.drive(5'($urandom), 1'b1, 1'($urandom), 1'b0);
    nbr.level(1'b1);
    nbr.level(1'b0);
    chk(x, 1'b1);
    wb(1'b1, 8'h08, 32'h8ea, 4'hf, rd);
    nbr.level(1'b1);
    nbr.level(1'b0);
    chk(x, 1'b0);
    $display("test clear done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wb(1'b0, 8'h08, 32'h0, 4'h0, rd);
    chk(rd, 32'h800);
    $display("test reset done");
    test_done;
  end
  // the tests need far fewer cycles than this span
  initial begin
    #40000;
    n_mismatch++;
    test_done;
  end
endmodule // lcell_top_tb
`default_nettype wire
